// File: scp_pins.sv
/*
 Pin logic for two serial channels: clock steering, sync pin modes,
 modem control, DMA/wait pins and pin sharing, behind an APB slave.
 Assumes a 20 MHz sys_clk; pins are asynchronous to it.
*/
`include "scp_params.svh"
module scp_pins
   import scp_pkg::*;
#(
   parameter int NCH = 2
) (
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          rst,
   // APB
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic               pslverr,
   output logic [31:0]        prdata,
   // Pins in, both channels (index 0 = A)
   input  wire logic [NCH-1:0] syncPinIn,
   input  wire logic [NCH-1:0] clearToSendN,
   input  wire logic [NCH-1:0] carrierDetectN,
   input  wire logic [NCH-1:0] bidirClockPinIn,
   input  wire logic [NCH-1:0] clockInputPin,
   // Core side per channel
   input  scp_core_t [NCH-1:0] core,
   input  wire logic [NCH-1:0] loopClk,
   input  wire logic [NCH-1:0] oscClk,
   input  wire logic [NCH-1:0] baudClk,
   input  wire logic [NCH-1:0] txClkInt,
   input  wire logic          memoryWriteStrobeN,
   // Clock steering results
   output logic [NCH-1:0]     rxClkSel,
   output logic [NCH-1:0]     txClkSel,
   output logic [NCH-1:0]     baudSrc,
   output logic [NCH-1:0]     loopSrc,
   output logic [NCH*2-1:0]   rxClkMul,
   output logic [NCH-1:0]     xtalMode,
   // Pins out
   output logic [NCH-1:0]     bidirClockPinOut,
   output logic [NCH-1:0]     bidirClockPinOe,
   output logic [NCH-1:0]     syncPinOut,
   output logic [NCH-1:0]     syncPinOe,
   output logic [NCH-1:0]     requestToSendN,
   output logic [NCH-1:0]     terminalReadyReqN,
   output logic [NCH-1:0]     waitRequestOut,
   output logic [NCH-1:0]     waitRequestOe,
   output logic               channelAReqPinN,
   // Core enables and events
   output logic [NCH-1:0]     txEnable,
   output logic [NCH-1:0]     rxEnable,
   output logic [NCH-1:0]     rxAssembleStart,
   output logic [NCH-1:0]     hostMode,
   output logic               portCShare
);
   // Pin sharing is wired for channels A and B only
   if (NCH != 2) begin : gBadNch
      $error("scp_pins serves exactly two channels");
   end

   // Register state
   scp_cfg_t      cfg_reg  [NCH];
   scp_cfg_t      cfg_next [NCH];
   scp_ctl_t      ctl_reg  [NCH];
   scp_ctl_t      ctl_next [NCH];
   logic [NCH-1:0] syncHunt_reg, syncHunt_next;
   logic [NCH-1:0] ctsEdge_reg, ctsEdge_next;
   logic [NCH-1:0] dcdEdge_reg, dcdEdge_next;
   logic [3:0]     sys_reg, sys_next;
   logic           pready_next;
   logic [31:0]    prdata_next;
   logic           pslverr_next;

   // Input synchronisers: meta stage feeds only the second stage
   logic [NCH-1:0] syncM, syncS, syncD;
   logic [NCH-1:0] ctsM, ctsS, ctsD, dcdM, dcdS, dcdD;
   logic [NCH-1:0] rxcM, rxcS, rxcD, trxM, trxS;
   always_ff @(posedge sys_clk) begin
      syncM <= syncPinIn;
      syncS <= syncM;
      syncD <= syncS;
      ctsM  <= clearToSendN;
      ctsS  <= ctsM;
      ctsD  <= ctsS;
      dcdM  <= carrierDetectN;
      dcdS  <= dcdM;
      dcdD  <= dcdS;
      rxcM  <= clockInputPin;
      rxcS  <= rxcM;
      rxcD  <= rxcS;
      trxM  <= bidirClockPinIn;
      trxS  <= trxM;
   end

   wire apbWr = psel && penable && pwrite && !pready;
   wire apbRd = psel && penable && !pwrite && !pready;
   wire mapped = (paddr <= `SCP_OFF_SYS) && (paddr[1:0] == 2'b00);

   // Register next state and read mux
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         cfg_next[i] = cfg_reg[i];
         ctl_next[i] = ctl_reg[i];
      end
      sys_next      = sys_reg;
      syncHunt_next = syncHunt_reg;
      ctsEdge_next  = ctsEdge_reg;
      dcdEdge_next  = dcdEdge_reg;
      pready_next   = psel && penable && !pready;
      pslverr_next  = psel && penable && !pready && !mapped;
      prdata_next   = 32'h0000_0000;
      // Clear-by-write first, so edges below win over the clear
      if (apbWr) begin
         case (paddr)
            `SCP_OFF_CFG_A:  cfg_next[0] = pwdata[$bits(scp_cfg_t)-1:0];
            `SCP_OFF_CFG_B:  cfg_next[1] = pwdata[$bits(scp_cfg_t)-1:0];
            `SCP_OFF_CTL_A:  ctl_next[0] = pwdata[1:0];
            `SCP_OFF_CTL_B:  ctl_next[1] = pwdata[1:0];
            `SCP_OFF_STAT_A: begin
               ctsEdge_next[0] = ctsEdge_reg[0] & ~pwdata[`SCP_STAT_CTS_BIT];
               dcdEdge_next[0] = dcdEdge_reg[0] & ~pwdata[`SCP_STAT_DCD_BIT];
            end
            `SCP_OFF_STAT_B: begin
               ctsEdge_next[1] = ctsEdge_reg[1] & ~pwdata[`SCP_STAT_CTS_BIT];
               dcdEdge_next[1] = dcdEdge_reg[1] & ~pwdata[`SCP_STAT_DCD_BIT];
            end
            `SCP_OFF_SYS:    sys_next = pwdata[3:0];
            default: ;
         endcase
      end
      for (int i = 0; i < NCH; i++) begin
         if (ctsS[i] != ctsD[i]) ctsEdge_next[i] = 1'b1;
         if (dcdS[i] != dcdD[i]) dcdEdge_next[i] = 1'b1;
         // Sync pin input only moves the hunt status in async
         if (scp_mode_t'(cfg_reg[i].mode) == SCP_ASYNC && !cfg_reg[i].xtalEn) begin
            syncHunt_next[i] = ~syncS[i];
         end else begin
            syncHunt_next[i] = 1'b0;
         end
      end
      if (apbRd) begin
         case (paddr)
            `SCP_OFF_CFG_A:  prdata_next = 32'(cfg_reg[0]);
            `SCP_OFF_CFG_B:  prdata_next = 32'(cfg_reg[1]);
            `SCP_OFF_CTL_A:  prdata_next = 32'(ctl_reg[0]);
            `SCP_OFF_CTL_B:  prdata_next = 32'(ctl_reg[1]);
            `SCP_OFF_STAT_A: prdata_next = {27'h0, ~ctsS[0], ~dcdS[0], dcdEdge_reg[0],
                                            ctsEdge_reg[0], syncHunt_reg[0]};
            `SCP_OFF_STAT_B: prdata_next = {27'h0, ~ctsS[1], ~dcdS[1], dcdEdge_reg[1],
                                            ctsEdge_reg[1], syncHunt_reg[1]};
            `SCP_OFF_SYS:    prdata_next = {28'h0, sys_reg};
            default:         prdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < NCH; i++) begin
            cfg_reg[i] <= scp_cfg_t'(`SCP_CFG_RESET);   // Wait function selected
            ctl_reg[i] <= scp_ctl_t'(`SCP_CTL_RESET);
         end
         sys_reg      <= 4'(`SCP_SYS_RESET);    // Write strobe owns pin
         syncHunt_reg <= '0;
         ctsEdge_reg  <= '0;
         dcdEdge_reg  <= '0;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
         prdata       <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            cfg_reg[i] <= cfg_next[i];
            ctl_reg[i] <= ctl_next[i];
         end
         sys_reg      <= sys_next;
         syncHunt_reg <= syncHunt_next;
         ctsEdge_reg  <= ctsEdge_next;
         dcdEdge_reg  <= dcdEdge_next;
         pready       <= pready_next;
         pslverr      <= pslverr_next;
         prdata       <= prdata_next;
      end
   end

   // Per-channel pin logic, all outputs registered
   logic [NCH-1:0] rtsHold_reg, rtsHold_next;
   logic [NCH-1:0] rxClkSelN, txClkSelN, baudN, loopN, xtalN, trxOutN, trxOeN;
   logic [NCH-1:0] syncOutN, syncOeN, rtsN, dtrN, wOutN, wOeN, txEnN, rxEnN, asmN;
   logic [NCH*2-1:0] mulN;
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gCh
         scp_cfg_t  c;
         scp_mode_t m;
         assign c = cfg_reg[g];
         assign m = scp_mode_t'(c.mode);
         always_comb begin
            // Clock input pin steered to one of four uses
            rxClkSelN[g] = (c.rtxcUse == 2'd0) ? rxcS[g]
                         : (!c.trxcOut && c.trxcInRx) ? trxS[g] : 1'b0;
            txClkSelN[g] = (c.rtxcUse == 2'd1) ? rxcS[g]
                         : (!c.trxcOut && !c.trxcInRx) ? trxS[g] : txClkInt[g];
            baudN[g] = (c.rtxcUse == 2'd2) ? rxcS[g] : 1'b0;
            loopN[g] = (c.rtxcUse == 2'd3) ? rxcS[g] : 1'b0;
            mulN[g*2 +: 2] = (m == SCP_ASYNC) ? c.rxClkMul : 2'd0;
            xtalN[g] = c.xtalEn;
            trxOeN[g] = c.trxcOut;
            case (c.trxcOutSel)
               2'd0:    trxOutN[g] = loopClk[g];
               2'd1:    trxOutN[g] = oscClk[g];
               2'd2:    trxOutN[g] = baudClk[g];
               default: trxOutN[g] = txClkInt[g];
            endcase
            // Sync pin role; crystal mode releases it
            syncOeN[g]  = 1'b0;
            syncOutN[g] = 1'b1;
            if (!c.xtalEn) begin
               case (m)
                  SCP_MONOBI: begin
                     syncOeN[g]  = 1'b1;
                     syncOutN[g] = ~core[g].syncMatch;
                  end
                  SCP_SDLC: begin
                     syncOeN[g]  = 1'b1;
                     syncOutN[g] = ~core[g].flagSeen;
                  end
                  default: ;
               endcase
            end
            // Falling edge of the synchronised sync pin starts assembly in external sync
            asmN[g] = (m == SCP_EXTSYNC) && !c.xtalEn && syncD[g] && !syncS[g];
            txEnN[g] = c.autoEn ? ~ctsS[g] : 1'b1;
            rxEnN[g] = c.autoEn ? ~dcdS[g] : 1'b1;
            // Request-to-send release waits for empty transmitter in async auto
            if (ctl_reg[g].rts) begin
               rtsHold_next[g] = 1'b1;
            end else if (m == SCP_ASYNC && c.autoEn) begin
               rtsHold_next[g] = rtsHold_reg[g] && !core[g].txEmpty;
            end else begin
               rtsHold_next[g] = 1'b0;
            end
            rtsN[g] = ~rtsHold_next[g];
            dtrN[g] = c.dtrReq ? ~core[g].txDmaReq : ~ctl_reg[g].dtr;
            // Wait pulls low only; request drives both levels
            if (c.waitReq) begin
               wOeN[g]  = 1'b1;
               wOutN[g] = ~core[g].rxDmaReq;
            end else begin
               wOeN[g]  = core[g].waitAct;
               wOutN[g] = 1'b0;
            end
         end
      end
   endgenerate

   // Output registers; host mode takes the channel B clock and sync pins off the line
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rtsHold_reg <= '0;
         rxClkSel <= '0; txClkSel <= '0; baudSrc <= '0; loopSrc <= '0;
         rxClkMul <= '0; xtalMode <= '0;
         bidirClockPinOut <= '0; bidirClockPinOe <= '0;
         syncPinOut <= '1; syncPinOe <= '0;
         requestToSendN <= '1; terminalReadyReqN <= '1;
         waitRequestOut <= '0; waitRequestOe <= '0;
         channelAReqPinN <= 1'b1;
         txEnable <= '0; rxEnable <= '0; rxAssembleStart <= '0;
         hostMode <= '0; portCShare <= 1'b0;
      end else begin
         rtsHold_reg <= rtsHold_next;
         rxClkSel <= rxClkSelN; txClkSel <= txClkSelN;
         baudSrc <= baudN; loopSrc <= loopN; rxClkMul <= mulN; xtalMode <= xtalN;
         bidirClockPinOut <= trxOutN;
         bidirClockPinOe  <= trxOeN;
         syncPinOut <= syncOutN;
         syncPinOe  <= syncOeN;
         requestToSendN <= rtsN;
         terminalReadyReqN <= dtrN;
         waitRequestOut <= wOutN;
         waitRequestOe  <= wOeN;
         txEnable <= txEnN;
         rxEnable <= rxEnN;
         rxAssembleStart <= asmN;
         hostMode <= {NCH{1'b0}} | {sys_reg[`SCP_HOST_BIT], 1'b0};
         if (sys_reg[`SCP_HOST_BIT]) begin
            bidirClockPinOe[1] <= 1'b0;
            syncPinOe[1]       <= 1'b0;
         end
         portCShare <= sys_reg[`SCP_PORTC_BIT];
         if (sys_reg[`SCP_PORTC_BIT]) begin
            syncPinOe[0]     <= 1'b0;
            waitRequestOe[0] <= 1'b0;
         end
         channelAReqPinN <= sys_reg[`SCP_MUX_BIT] ? rtsN[0] : memoryWriteStrobeN;
      end
   end

   // Assertions
   sequence s_rtsSet(i);
      ctl_reg[i].rts;
   endsequence
   a_rts_low_a: assert property (@(posedge sys_clk) disable iff (rst)
      s_rtsSet(0) |=> !requestToSendN[0]) else $error("rts A not low");
   a_rts_follow: assert property (@(posedge sys_clk) disable iff (rst)
      (!cfg_reg[0].autoEn && !ctl_reg[0].rts) |=> requestToSendN[0])
      else $error("rts A not following bit");
   a_rts_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (cfg_reg[0].mode == 2'd0 && cfg_reg[0].autoEn && !ctl_reg[0].rts
       && rtsHold_reg[0] && !core[0].txEmpty) |=> !requestToSendN[0])
      else $error("rts A released early");
   a_cts_enable: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_reg[0].autoEn |=> txEnable[0] == !$past(ctsS[0]))
      else $error("tx enable wrong");
   a_dcd_enable: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_reg[0].autoEn |=> rxEnable[0] == !$past(dcdS[0]))
      else $error("rx enable wrong");
   a_cts_edge: assert property (@(posedge sys_clk) disable iff (rst)
      (ctsS[0] != ctsD[0]) |=> ctsEdge_reg[0]) else $error("cts edge lost");
   a_wait_drive: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg_reg[0].waitReq |=> !waitRequestOut[0]) else $error("wait drives high");
   a_host_release: assert property (@(posedge sys_clk) disable iff (rst)
      sys_reg[`SCP_HOST_BIT] |=> !syncPinOe[1]) else $error("host pin driven");
   a_mux_strobe: assert property (@(posedge sys_clk) disable iff (rst)
      !sys_reg[`SCP_MUX_BIT] |=> channelAReqPinN == $past(memoryWriteStrobeN))
      else $error("strobe mux wrong");
endmodule

// File: scp_params.svh
/*
 Constants for the serial channel pin logic: register offsets, field
 positions, reset values and encodings. Assumes inclusion by bare name.
*/
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
`define SCP_OFF_CFG_A    12'h000
`define SCP_OFF_CFG_B    12'h004
`define SCP_OFF_CTL_A    12'h008
`define SCP_OFF_CTL_B    12'h00C
`define SCP_OFF_STAT_A   12'h010
`define SCP_OFF_STAT_B   12'h014
`define SCP_OFF_SYS      12'h018
`define SCP_CFG_RESET    32'h0000_0000
`define SCP_CTL_RESET    32'h0000_0000
`define SCP_SYS_RESET    32'h0000_0000
`define SCP_MUX_BIT      3
`define SCP_HOST_BIT     0
`define SCP_PORTC_BIT    1
`define SCP_STAT_CTS_BIT 1
`define SCP_STAT_DCD_BIT 2
`define SCP_WAIT_OFF     32'h0000_0000
`endif

// File: scp_pkg.sv
/*
 Types for the serial channel pin logic. Assumes scp_params.svh exists.
*/
package scp_pkg;
   // Protocol mode of a channel
   typedef enum logic [1:0] {
      SCP_ASYNC,
      SCP_EXTSYNC,
      SCP_MONOBI,
      SCP_SDLC
   } scp_mode_t;
   // Channel configuration, low bits of CFG register
   typedef struct packed {
      logic [1:0] rxClkMul;   // 0:x1 1:x16 2:x32 3:x64
      logic       trxcOut;    // Bidir clock pin is output
      logic [1:0] trxcOutSel; // 0 loop 1 osc 2 baud 3 txclk
      logic       trxcInRx;   // Input feeds receive (else transmit)
      logic [1:0] rtxcUse;    // 0 rx 1 tx 2 baud 3 loop
      logic       xtalEn;     // Oscillator uses sync pin
      logic       autoEn;
      logic       waitReq;    // 1: receive DMA request drive
      logic       dtrReq;     // 1: terminal pin is transmit request
      logic [1:0] mode;
   } scp_cfg_t;
   // Channel control bits
   typedef struct packed {
      logic dtr;
      logic rts;
   } scp_ctl_t;
   // Per-channel inputs from the core
   typedef struct packed {
      logic txEmpty;
      logic syncMatch;
      logic flagSeen;
      logic rxDmaReq;
      logic txDmaReq;
      logic waitAct;
   } scp_core_t;
endpackage

// File: scp_line_model.sv
/*
 Far-side model: line clocks, modem lines, external sync source and the
 DMA controller. Assumes the bench resolves the shared pins around it.
*/
module scp_line_model (
   // Clock and commands from the bench
   input  wire logic       sys_clk,
   input  wire logic       frameOn,
   input  wire logic       syncReq,
   input  wire logic       idleLevel,
   input  wire logic [1:0] ctsCmdN,
   input  wire logic [1:0] dcdCmdN,
   // Device pins seen by the far side
   input  wire logic [1:0] terminalReadyReqN,
   input  wire logic [1:0] waitWire,
   output logic      [1:0] clockInputPin,
   output logic      [1:0] bidirClockPinIn,
   output logic      [1:0] syncDrvN,
   output logic      [1:0] clearToSendN,
   output logic      [1:0] carrierDetectN,
   output logic            bothReqSeen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       rxClk = 1'h0;
   logic       busy = 1'h0;
   logic [3:0] bitCnt = 4'h0;
   initial bothReqSeen = 1'h0;
   // Line clock stands at the commanded level outside frames, phase unrelated to sys_clk
   always begin
      #85;
      if (frameOn)
         rxClk = ~rxClk;
      else
         rxClk = idleLevel;
   end
   assign clockInputPin = {2{rxClk}};
   assign bidirClockPinIn = {2{~rxClk}};
   assign clearToSendN = ctsCmdN;
   assign carrierDetectN = dcdCmdN;
   assign syncDrvN[1] = 1'h1;
   // Eight-bit sync character, then sync pulled low two clocks later
   always @(posedge rxClk) begin
      if (!busy && syncReq) begin
         busy <= 1'h1;
         bitCnt <= 4'h0;
      end else if (busy) begin
         bitCnt <= bitCnt + 4'h1;
         busy <= (bitCnt != 4'hD);
      end
   end
   assign syncDrvN[0] = !(busy && bitCnt >= 4'h9);
   // DMA controller notes both request lines low in the same cycle
   always @(posedge sys_clk) begin
      if (terminalReadyReqN[0] == 1'h0 && waitWire[0] == 1'h0)
         bothReqSeen <= 1'h1;
   end
endmodule

// File: tb.sv
/*
 Self-checking bench for the serial channel pin logic, channel A mostly.
 Assumes scp_pkg, scp_params.svh and the line model are compiled first.
*/
`include "scp_params.svh"
module tb
   import scp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, memoryWriteStrobeN = 1'h1;
   logic [1:0]  syncPinIn, clearToSendN, carrierDetectN, bidirClockPinIn, clockInputPin;
   logic [1:0]  loopClk = 2'h0, oscClk = 2'h0, baudClk = 2'h0, txClkInt = 2'h0;
   logic [1:0]  rxClkSel, txClkSel, baudSrc, loopSrc, xtalMode, bidirClockPinOut;
   logic [1:0]  bidirClockPinOe, syncPinOut, syncPinOe, requestToSendN, terminalReadyReqN;
   logic [1:0]  waitRequestOut, waitRequestOe, txEnable, rxEnable, rxAssembleStart;
   logic [1:0]  hostMode, syncDrvN, waitWire, ctsCmdN = 2'h3, dcdCmdN = 2'h3;
   logic [3:0]  rxClkMul, src;
   logic        channelAReqPinN, portCShare, frameOn = 1'h0, syncReq = 1'h0, bothReqSeen;
   logic        idleLevel = 1'h0;
   scp_core_t [1:0] core = '0;
   scp_cfg_t    cfg;
   int          err_count = 0, checks = 0, cycles = 0, n;

   // Shared pins: device drives sync when enabled, wait line has a pull-up
   assign syncPinIn = (syncPinOe & syncPinOut) | (~syncPinOe & syncDrvN);
   assign waitWire = ~waitRequestOe | waitRequestOut;

   scp_pins u_scp_pins (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .pslverr, .prdata, .syncPinIn, .clearToSendN, .carrierDetectN, .bidirClockPinIn,
      .clockInputPin, .core, .loopClk, .oscClk, .baudClk, .txClkInt, .memoryWriteStrobeN,
      .rxClkSel, .txClkSel, .baudSrc, .loopSrc, .rxClkMul, .xtalMode, .bidirClockPinOut,
      .bidirClockPinOe, .syncPinOut, .syncPinOe, .requestToSendN, .terminalReadyReqN,
      .waitRequestOut, .waitRequestOe, .channelAReqPinN, .txEnable, .rxEnable,
      .rxAssembleStart, .hostMode, .portCShare);
   scp_line_model u_scp_line_model (.sys_clk, .frameOn, .syncReq, .ctsCmdN, .dcdCmdN,
      .terminalReadyReqN, .waitWire, .clockInputPin, .bidirClockPinIn, .syncDrvN,
      .clearToSendN, .carrierDetectN, .bothReqSeen, .idleLevel);

   // Clock and hang guard
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wt(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      // Only the hang guard ends a wait that never sees pready
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic setcfg(input scp_cfg_t c);
      apb(1'h1, `SCP_OFF_CFG_A, 32'(c));
      wt(4);
   endtask

   // Main sequence
   initial begin
      void'($urandom(93));
      wt(6);
      rst <= 1'h0;
      chk("rtsN reset", requestToSendN, 2'h3);
      core[0].waitAct <= 1'h1;
      memoryWriteStrobeN <= 1'h0;
      wt(3);
      chk("wait oe", {waitRequestOe[0], waitWire[0]}, 2'h2);
      chk("strobe pin", channelAReqPinN, 1'h0);
      apb(1'h0, `SCP_OFF_CFG_A, 32'h0);
      chk("cfg reset", rd, `SCP_CFG_RESET);
      apb(1'h0, `SCP_OFF_SYS, 32'h0);
      chk("sys reset", rd, `SCP_SYS_RESET);
      apb(1'h0, 12'h01C, 32'h0);
      chk("unmapped err", err, 1'h1);
      chk("unmapped data", rd, 32'h0);
      apb(1'h1, 12'h006, 32'hFFFF_FFFF);
      chk("misaligned", err, 1'h1);
      // Clock pin output sources and input steering
      for (int s = 0; s < 4; s++) begin
         {loopClk, oscClk, baudClk, txClkInt} <= 8'($urandom);
         idleLevel <= 1'(s);
         cfg = '0;
         cfg.trxcOut = 1'h1;
         cfg.trxcOutSel = 2'(s);
         setcfg(cfg);
         src = {txClkInt[0], baudClk[0], oscClk[0], loopClk[0]};
         chk("bidir out", {bidirClockPinOe[0], bidirClockPinOut[0]}, {1'h1, src[s]});
         cfg = '0;
         cfg.rtxcUse = 2'(s);
         cfg.trxcInRx = (s != 0);
         setcfg(cfg);
         wt(4);
         src = {loopSrc[0], baudSrc[0], txClkSel[0], rxClkSel[0]};
         chk("clock in use", src[s], clockInputPin[0]);
         chk("bidir in", cfg.trxcInRx ? rxClkSel[0] : txClkSel[0], bidirClockPinIn[0]);
      end
      idleLevel <= 1'h0;
      // Receive clock multiplier, async only; every setting once
      for (int m = 0; m < 4; m++) begin
         cfg = '0;
         cfg.rxClkMul = 2'(m);
         setcfg(cfg);
         chk("mul async", rxClkMul[1:0], cfg.rxClkMul);
      end
      cfg.mode = SCP_SDLC;
      setcfg(cfg);
      chk("mul sync", rxClkMul[1:0], 2'h0);
      // Sync output pulses in mono/bisync and SDLC
      for (int k = 0; k < 2; k++) begin
         cfg = '0;
         cfg.mode = k ? SCP_SDLC : SCP_MONOBI;
         setcfg(cfg);
         chk("sync oe", syncPinOe[0], 1'h1);
         for (int r = 0; r < 2; r++) begin
            core[0].syncMatch <= (k == 0);
            core[0].flagSeen <= (k == 1);
            wt(1);
            core[0].syncMatch <= 1'h0;
            core[0].flagSeen <= 1'h0;
            n = 0;
            repeat (4) begin
               wt(1);
               n += !syncPinOut[0];
            end
            chk("sync pulse", n, 1);
            chk("sync idle", syncPinOut[0], 1'h1);
         end
      end
      cfg.xtalEn = 1'h1;
      setcfg(cfg);
      chk("xtal", {xtalMode[0], syncPinOe[0]}, 2'h2);
      // External sync: one assembly start per sync character
      cfg = '0;
      cfg.mode = SCP_EXTSYNC;
      setcfg(cfg);
      chk("ext oe", syncPinOe[0], 1'h0);
      frameOn <= 1'h1;
      syncReq <= 1'h1;
      wt(6);
      syncReq <= 1'h0;
      n = 0;
      repeat (120) begin
         wt(1);
         n += rxAssembleStart[0];
      end
      frameOn <= 1'h0;
      chk("assemble", n, 1);
      // Request-to-send follows the bit in sync mode
      apb(1'h1, `SCP_OFF_CTL_A, 32'h1);
      wt(3);
      chk("rts set", requestToSendN[0], 1'h0);
      apb(1'h1, `SCP_OFF_CTL_A, 32'h0);
      wt(3);
      chk("rts follow", requestToSendN[0], 1'h1);
      // Async auto enable: rts held until transmitter empty
      cfg = '0;
      cfg.autoEn = 1'h1;
      setcfg(cfg);
      apb(1'h1, `SCP_OFF_CTL_A, 32'h1);
      apb(1'h1, `SCP_OFF_CTL_A, 32'h0);
      wt(6);
      chk("rts hold", requestToSendN[0], 1'h0);
      core[0].txEmpty <= 1'h1;
      wt(3);
      chk("rts empty", requestToSendN[0], 1'h1);
      // Modem inputs: enables and both edges
      ctsCmdN <= 2'h2;
      dcdCmdN <= 2'h2;
      wt(8);
      chk("enables", {txEnable[0], rxEnable[0]}, 2'h3);
      apb(1'h0, `SCP_OFF_STAT_A, 32'h0);
      chk("fall edges", rd & 32'h1E, 32'h1E);
      apb(1'h1, `SCP_OFF_STAT_A, 32'h6);
      ctsCmdN <= 2'h3;
      wt(8);
      chk("tx off", txEnable[0], 1'h0);
      apb(1'h0, `SCP_OFF_STAT_A, 32'h0);
      chk("rise edge", rd & 32'h16, 32'h02);
      // Async: sync pin moves only the hunt bit, never starts assembly
      frameOn <= 1'h1;
      syncReq <= 1'h1;
      wt(6);
      syncReq <= 1'h0;
      n = 0;
      repeat (32) begin
         wt(1);
         n += rxAssembleStart[0];
      end
      apb(1'h0, `SCP_OFF_STAT_A, 32'h0);
      chk("hunt low", rd[0], 1'h1);
      repeat (30) begin
         wt(1);
         n += rxAssembleStart[0];
      end
      frameOn <= 1'h0;
      apb(1'h0, `SCP_OFF_STAT_A, 32'h0);
      chk("hunt high", rd[0], 1'h0);
      chk("async no asm", n, 0);
      // DMA requests on both lines at once
      cfg.dtrReq = 1'h1;
      cfg.waitReq = 1'h1;
      setcfg(cfg);
      core[0].txDmaReq <= 1'h1;
      core[0].rxDmaReq <= 1'h1;
      wt(3);
      chk("dma low", {terminalReadyReqN[0], waitRequestOe[0], waitWire[0]}, 3'h2);
      chk("dma both", bothReqSeen, 1'h1);
      core[0].txDmaReq <= 1'h0;
      core[0].rxDmaReq <= 1'h0;
      wt(3);
      chk("dma high", {terminalReadyReqN[0], waitRequestOe[0], waitRequestOut[0]}, 3'h7);
      cfg.dtrReq = 1'h0;
      cfg.waitReq = 1'h0;
      setcfg(cfg);
      apb(1'h1, `SCP_OFF_CTL_A, 32'h3);
      wt(3);
      chk("dtr", terminalReadyReqN[0], 1'h0);
      // Pin sharing
      apb(1'h1, `SCP_OFF_SYS, 32'h0000_000B);
      wt(3);
      chk("host", {hostMode, portCShare}, 3'h5);
      chk("rts pin", {channelAReqPinN, waitRequestOe[0]}, 2'h0);
      print_verdict();
   end
endmodule
